// *** inc/csic_pkg.sv ***
package csic_pkg;
  localparam int IRQ_MAX = 32;
  localparam int PRIO_W = 2;
  localparam int XPRIO_W = 3;
  localparam int EXC_NUM_W = 6;
  localparam int STACK_WORDS = 8;
  localparam logic [31:0] STACK_FRAME_BYTES = 32'h0000_0020;
  localparam logic [2:0] STACK_XPSR_IDX = 3'h7;
  localparam int FLAG_MSB = 31;
  localparam int FLAG_LSB = 28;
  localparam int CTRL_SPSEL_BIT = 1;
  localparam int PRIO_FIELD_W = 8;
  localparam int PRIO_FIELD_MSB = 7;
  localparam int PRIO_FIELD_LSB = 6;
  // bus regions
  localparam logic [31:0] RGN_IRQC_LO = 32'hE000_E100;
  localparam logic [31:0] RGN_IRQC_HI = 32'hE000_E4EF;
  localparam logic [31:0] RGN_IRQC2_LO = 32'hE000_EF00;
  localparam logic [31:0] RGN_IRQC2_HI = 32'hE000_EF03;
  localparam logic [31:0] RGN_TMR_LO = 32'hE000_E010;
  localparam logic [31:0] RGN_TMR_HI = 32'hE000_E01F;
  localparam logic [31:0] RGN_SCB1_LO = 32'hE000_E008;
  localparam logic [31:0] RGN_SCB1_HI = 32'hE000_E00F;
  localparam logic [31:0] RGN_SCB2_LO = 32'hE000_ED00;
  localparam logic [31:0] RGN_SCB2_HI = 32'hE000_ED3F;
  // register map
  localparam logic [31:0] ADDR_IRQ_ENABLE_SET = 32'hE000_E100;
  localparam logic [31:0] ADDR_IRQ_ENABLE_CLEAR = 32'hE000_E180;
  localparam logic [31:0] ADDR_IRQ_PENDING_SET = 32'hE000_E200;
  localparam logic [31:0] ADDR_IRQ_PENDING_CLEAR = 32'hE000_E280;
  localparam logic [31:0] ADDR_IRQ_PRIORITY_BASE = 32'hE000_E400;
  localparam logic [31:0] ADDR_IRQ_PRIORITY_LAST = 32'hE000_E41C;
  localparam logic [31:0] RST_IRQ_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_PENDING = 32'h0000_0000;
  localparam logic [PRIO_W-1:0] RST_IRQ_PRIORITY = 2'h0;
  // exception numbers and extended priorities (NMI above all levels)
  localparam logic [5:0] EXC_NUM_THREAD = 6'h00;
  localparam logic [5:0] EXC_NUM_NMI = 6'h02;
  localparam logic [5:0] EXC_NUM_SVC = 6'h0B;
  localparam logic [5:0] EXC_NUM_IRQ0 = 6'h10;
  localparam logic [2:0] XPRIO_NMI = 3'h0;
  localparam logic [2:0] XPRIO_MASKED = 3'h1;
  localparam logic [2:0] XPRIO_THREAD = 3'h5;

  typedef enum logic [3:0] {
    OP_IDLE, OP_SYNC_BARRIER, OP_MOVE_FROM, OP_MOVE_TO, OP_NO_OPERATION,
    OP_SEND_EVENT, OP_SUPER_CALL, OP_WAIT_EVENT, OP_WAIT_IRQ
  } csic_op_t;

  typedef enum logic [3:0] {
    SPEC_APP, SPEC_EXC, SPEC_EXE, SPEC_EXC_EXE, SPEC_APP_EXC, SPEC_APP_EXE,
    SPEC_ALL, SPEC_MAIN_SP, SPEC_PROC_SP, SPEC_IRQ_MASK, SPEC_CONTROL
  } csic_spec_t;

  typedef enum logic [2:0] {
    XS_RUN, XS_PUSH, XS_VECTOR, XS_RETURN, XS_POP
  } csic_xstate_t;

  typedef struct packed {
    logic        valid;
    csic_op_t    op;
    csic_spec_t  spec;
    logic [31:0] src;
  } csic_instr_t;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } csic_ppb_req_t;

  typedef struct packed {
    logic        ready;
    logic        err;
    logic [31:0] rdata;
  } csic_ppb_rsp_t;

  typedef struct packed {
    logic        we;
    logic        re;
    logic [31:0] addr;
    logic [31:0] wdata;
  } csic_stack_t;
endpackage

// *** core/csic_irq_arb.sv ***
`timescale 1ns/100ps
module csic_irq_arb
  import csic_pkg::*;
#(
  parameter int NUM_IRQ = 32
) (
  input  logic [NUM_IRQ-1:0]             req,
  input  logic [NUM_IRQ-1:0][PRIO_W-1:0] prio,
  output logic                           found,
  output logic [4:0]                     id,
  output logic [PRIO_W-1:0]              best_prio
);
  if (NUM_IRQ < 1 || NUM_IRQ > IRQ_MAX) begin : g_chk
    $error("csic_irq_arb: NUM_IRQ out of range");
  end

  // scan downward with <= so equal levels go to the lowest number
  always_comb begin
    found     = 1'b0;
    id        = 5'h00;
    best_prio = '1;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i] && (!found || prio[i] <= best_prio)) begin
        found     = 1'b1;
        id        = 5'(i);
        best_prio = prio[i];
      end
    end
  end
endmodule

// *** core/csic_wait_unit.sv ***
`timescale 1ns/100ps
module csic_wait_unit
  import csic_pkg::*;
#(
  parameter bit EVENT_WAIT_EN = 1'b1
) (
  input  logic clk,
  input  logic rst_b,
  input  logic do_sev,
  input  logic do_wfe,
  input  logic do_wfi,
  input  logic wake_exc,
  input  logic wake_pend,
  input  logic wake_irq,
  input  logic wake_on_pending_flag,
  input  logic dbg_req,
  input  logic dbg_en,
  input  logic ext_event,
  output logic stall,
  output logic tx_event
);
  typedef struct packed {
    logic evt;
    logic w_evt;
    logic w_irq;
    logic tx;
  } csic_wait_state_t;

  csic_wait_state_t s, n;
  logic             wake_e;
  logic             wake_i;

  always_comb begin
    n      = s;
    wake_e = wake_exc | (wake_on_pending_flag & wake_pend) |
             (dbg_req & dbg_en) | ext_event;
    wake_i = wake_exc | wake_irq | dbg_req;
    n.tx   = do_sev;
    if (s.w_evt && wake_e) begin
      n.w_evt = 1'b0;
      n.evt   = 1'b0;
    end
    if (s.w_irq && wake_i)
      n.w_irq = 1'b0;
    if (do_wfe) begin
      if (s.evt)
        n.evt = 1'b0;
      else if (EVENT_WAIT_EN)
        n.w_evt = 1'b1;
    end
    if (do_wfi && EVENT_WAIT_EN)
      n.w_irq = 1'b1;
    // an arriving event beats a clear in the same cycle
    if (do_sev || ext_event)
      n.evt = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      s <= '0;
    else
      s <= n;
  end

  assign stall    = s.w_evt | s.w_irq;
  assign tx_event = s.tx;
endmodule

// *** core/csic_top.sv ***
`timescale 1ns/100ps
// Functional notes
// - barrier flushes pipeline, refetch after completion
// - move-from copies special register to destination
// - move-to writes source into chosen special register
// - status move-to loads flags from source bits
// - no-operation has no effect at all
// - send-event signals out and sets event register
// - supervisor call raises its exception, immediate ignored
// - wait-event with flag clear stalls until wake
// - wait-event with flag set clears and retires
// - wait-event may behave as no-operation
// - wait-interrupt stalls until exception, irq, debug
// - wait-interrupt may behave as no-operation
// - system instructions other than status move-to leave condition flags unchanged
// - peripheral bus decodes five documented regions
// - thirty-two inputs, each with level 0-3
// - lower level number wins arbitration
// - held levels and pulses both recognised
// - tail-chaining and non-maskable input supported
// - hardware stacks on entry, unstacks on exit
// - enable, pending, priority registers reset zero
// - only enabled pending interrupts get activated
// - pending-set one forces pending, zero ignored
// - pending-clear leaves active state alone
// - priority bytes keep bits 7:6 only
module csic_top
  import csic_pkg::*;
#(
  parameter int               NUM_IRQ       = 32,
  parameter logic [XPRIO_W-1:0] SVC_XPRIO   = 3'h1,
  parameter bit               EVENT_WAIT_EN = 1'b1
) (
  input  logic          clk,
  input  logic          rst_b,
  input  csic_instr_t   instr,
  output logic          instr_stall,
  output logic          gpr_we,
  output logic [31:0]   gpr_wdata,
  output logic          pipe_flush,
  output logic [3:0]    app_flags,
  output logic [5:0]    exc_num,
  output logic          vec_req,
  input  logic [31:0]   irq_line,
  input  logic          nmi_line,
  input  logic          wake_on_pending_flag,
  input  logic          dbg_req,
  input  logic          dbg_en,
  input  logic          ext_event,
  output logic          tx_event,
  input  csic_ppb_req_t ppb_req,
  output csic_ppb_rsp_t ppb_rsp,
  output logic          sel_systimer,
  output logic          sel_sysctrl,
  output csic_stack_t   stk,
  output logic [2:0]    ctx_idx,
  input  logic [31:0]   ctx_word,
  input  logic [31:0]   stk_rdata,
  input  logic          exc_return,
  input  logic          ret_to_psp
);
  if (NUM_IRQ < 1 || NUM_IRQ > IRQ_MAX) begin : g_chk_irq
    $error("csic_top: NUM_IRQ out of range");
  end
  if (SVC_XPRIO < XPRIO_MASKED || SVC_XPRIO >= XPRIO_THREAD) begin : g_chk_svc
    $error("csic_top: SVC_XPRIO out of range");
  end

  localparam logic [31:0] IMPL =
    (NUM_IRQ == IRQ_MAX) ? '1 : 32'((64'h1 << NUM_IRQ) - 64'h1);

  typedef struct packed {
    logic [31:0]             en;
    logic [31:0]             pend;
    logic [31:0]             act;
    logic [31:0]             line_q;
    logic [31:0][PRIO_W-1:0] prio;
    logic                    nmi_q;
    logic                    nmi_pend;
    logic                    nmi_act;
    logic                    svc_pend;
    logic                    svc_act;
    logic [3:0]              flags;
    logic [5:0]              exc_num;
    logic                    irq_mask;
    logic                    spsel;
    logic [31:0]             main_stack_ptr;
    logic [31:0]             process_stack_ptr;
    csic_xstate_t            st;
    logic [2:0]              idx;
    logic [5:0]              tgt;
    logic [31:0]             frame;
    logic                    push_psp;
    logic                    pop_psp;
    logic                    flush;
    logic                    gpr_we;
    logic [31:0]             gpr_wdata;
    logic                    rsp_ready;
    logic                    rsp_err;
    logic [31:0]             rsp_rdata;
  } csic_state_t;

  csic_state_t s, n;

  function automatic logic in_rng(input logic [31:0] a,
                                  input logic [31:0] lo,
                                  input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [XPRIO_W-1:0] irq_xprio(
    input logic [PRIO_W-1:0] p);
    return {1'b0, p} + 3'h1;
  endfunction

  // full status view; also the stacked status word
  function automatic logic [31:0] status_word(input logic [3:0] f,
                                              input logic [5:0] num);
    return {f, 22'h0, num};
  endfunction

  logic                arb_found;
  logic [4:0]          arb_id;
  logic [PRIO_W-1:0]   arb_prio;
  logic [XPRIO_W-1:0]  cur_xp;
  logic [XPRIO_W-1:0]  eff_xp;
  logic [XPRIO_W-1:0]  cand_xp;
  logic                cand_v;
  logic [5:0]          cand_num;
  logic                take_ok;
  logic                issue;
  logic                wait_stall;
  logic                irqc_hit;
  logic                tmr_hit;
  logic                scb_hit;
  logic                prio_hit;
  logic [31:0]         cur_sp;
  logic [31:0]         pop_base;
  logic [31:0]         sw_set;
  logic [31:0]         sw_clr;
  logic [31:0]         ent_clr;
  logic [31:0]         hw_set;
  logic [31:0]         pset;
  logic                act_go;
  logic [5:0]          act_num;
  logic [4:0]          act_irq;
  logic [4:0]          ret_irq;

  csic_irq_arb #(.NUM_IRQ(IRQ_MAX)) u_arb (
    .req       (s.pend & s.en & IMPL),
    .prio      (s.prio),
    .found     (arb_found),
    .id        (arb_id),
    .best_prio (arb_prio)
  );

  // current execution priority from the set of active handlers
  always_comb begin
    cur_xp = XPRIO_THREAD;
    if (s.svc_act && SVC_XPRIO < cur_xp)
      cur_xp = SVC_XPRIO;
    for (int i = 0; i < IRQ_MAX; i++) begin
      if (s.act[i] && irq_xprio(s.prio[i]) < cur_xp)
        cur_xp = irq_xprio(s.prio[i]);
    end
    if (s.nmi_act)
      cur_xp = XPRIO_NMI;
    // the global mask lets only the non-maskable input through
    eff_xp = (s.irq_mask && cur_xp > XPRIO_MASKED) ? XPRIO_MASKED : cur_xp;
  end

  always_comb begin
    cand_v   = 1'b1;
    cand_num = EXC_NUM_NMI;
    cand_xp  = XPRIO_NMI;
    if (s.nmi_pend && !s.nmi_act) begin
      cand_num = EXC_NUM_NMI;
    end else if (s.svc_pend &&
                 (!arb_found || SVC_XPRIO <= irq_xprio(arb_prio))) begin
      cand_num = EXC_NUM_SVC;
      cand_xp  = SVC_XPRIO;
    end else if (arb_found) begin
      cand_num = EXC_NUM_IRQ0 + {1'b0, arb_id};
      cand_xp  = irq_xprio(arb_prio);
    end else begin
      cand_v   = 1'b0;
      cand_xp  = XPRIO_THREAD;
    end
    take_ok = cand_v && (cand_xp < eff_xp);
  end

  always_comb begin
    irqc_hit = in_rng(ppb_req.addr, RGN_IRQC_LO, RGN_IRQC_HI) |
               in_rng(ppb_req.addr, RGN_IRQC2_LO, RGN_IRQC2_HI);
    tmr_hit  = in_rng(ppb_req.addr, RGN_TMR_LO, RGN_TMR_HI);
    scb_hit  = in_rng(ppb_req.addr, RGN_SCB1_LO, RGN_SCB1_HI) |
               in_rng(ppb_req.addr, RGN_SCB2_LO, RGN_SCB2_HI);
    prio_hit = in_rng(ppb_req.addr, ADDR_IRQ_PRIORITY_BASE,
                      ADDR_IRQ_PRIORITY_LAST) && ppb_req.addr[1:0] == 2'h0;
  end

  assign issue    = instr.valid & ~instr_stall;
  assign cur_sp   = (s.exc_num == EXC_NUM_THREAD && s.spsel) ? s.process_stack_ptr : s.main_stack_ptr;
  assign pop_base = s.pop_psp ? s.process_stack_ptr : s.main_stack_ptr;
  assign act_irq  = 5'(act_num - EXC_NUM_IRQ0);
  assign ret_irq  = 5'(s.exc_num - EXC_NUM_IRQ0);

  always_comb begin
    n           = s;
    n.line_q    = irq_line;
    n.nmi_q     = nmi_line;
    n.flush     = 1'b0;
    n.gpr_we    = 1'b0;
    n.rsp_ready = 1'b0;
    n.rsp_err   = 1'b0;
    sw_set      = '0;
    sw_clr      = '0;
    ent_clr     = '0;
    act_go      = 1'b0;
    act_num     = cand_num;

    // system instructions; flags move only on a status move-to
    if (issue) begin
      case (instr.op)
        OP_SYNC_BARRIER: n.flush = 1'b1;
        OP_MOVE_FROM: begin
          n.gpr_we = 1'b1;
          case (instr.spec)
            SPEC_APP:      n.gpr_wdata = status_word(s.flags, 6'h00);
            SPEC_EXC,
            SPEC_EXC_EXE:  n.gpr_wdata = status_word(4'h0, s.exc_num);
            SPEC_APP_EXE:  n.gpr_wdata = status_word(s.flags, 6'h00);
            SPEC_APP_EXC,
            SPEC_ALL:      n.gpr_wdata = status_word(s.flags, s.exc_num);
            SPEC_MAIN_SP:  n.gpr_wdata = s.main_stack_ptr;
            SPEC_PROC_SP:  n.gpr_wdata = s.process_stack_ptr;
            SPEC_IRQ_MASK: n.gpr_wdata = {31'h0, s.irq_mask};
            SPEC_CONTROL:  n.gpr_wdata = {30'h0, s.spsel, 1'b0};
            default:       n.gpr_wdata = 32'h0000_0000;
          endcase
        end
        OP_MOVE_TO: begin
          case (instr.spec)
            SPEC_APP, SPEC_APP_EXC, SPEC_APP_EXE, SPEC_ALL:
              n.flags = instr.src[FLAG_MSB:FLAG_LSB];
            SPEC_MAIN_SP: n.main_stack_ptr = {instr.src[31:2], 2'b00};
            SPEC_PROC_SP: n.process_stack_ptr = {instr.src[31:2], 2'b00};
            SPEC_IRQ_MASK: n.irq_mask = instr.src[0];
            SPEC_CONTROL: begin
              // stack select only changes in thread mode
              if (s.exc_num == EXC_NUM_THREAD)
                n.spsel = instr.src[CTRL_SPSEL_BIT];
            end
            default: ; // exception number and execution bits read-only
          endcase
        end
        OP_SUPER_CALL: n.svc_pend = 1'b1;
        default: ;
      endcase
    end

    // register slave: one-cycle answer to every request outside the timer and system-control regions
    if (ppb_req.sel && (irqc_hit || !(tmr_hit || scb_hit))) begin
      n.rsp_ready = 1'b1;
      n.rsp_err   = !irqc_hit;
      n.rsp_rdata = 32'h0000_0000;
      if (irqc_hit) begin
        case (ppb_req.addr)
          ADDR_IRQ_ENABLE_SET,
          ADDR_IRQ_ENABLE_CLEAR:  n.rsp_rdata = s.en;
          ADDR_IRQ_PENDING_SET,
          ADDR_IRQ_PENDING_CLEAR: n.rsp_rdata = s.pend;
          default: begin
            if (prio_hit) begin
              for (int b = 0; b < 4; b++)
                n.rsp_rdata[b*PRIO_FIELD_W+PRIO_FIELD_LSB +: PRIO_W] =
                  s.prio[{ppb_req.addr[4:2], 2'(b)}];
            end
          end
        endcase
        if (ppb_req.write) begin
          case (ppb_req.addr)
            ADDR_IRQ_ENABLE_SET:    n.en = (s.en | ppb_req.wdata) & IMPL;
            ADDR_IRQ_ENABLE_CLEAR:  n.en = s.en & ~ppb_req.wdata;
            ADDR_IRQ_PENDING_SET:   sw_set = ppb_req.wdata;
            ADDR_IRQ_PENDING_CLEAR: sw_clr = ppb_req.wdata;
            default: begin
              if (prio_hit) begin
                for (int b = 0; b < 4; b++)
                  n.prio[{ppb_req.addr[4:2], 2'(b)}] =
                    ppb_req.wdata[b*PRIO_FIELD_W+PRIO_FIELD_MSB -: PRIO_W];
              end
            end
          endcase
        end
      end
    end

    case (s.st)
      XS_RUN: begin
        if (take_ok) begin
          act_go     = 1'b1;
          n.tgt      = cand_num;
          n.frame    = cur_sp - STACK_FRAME_BYTES;
          n.push_psp = (s.exc_num == EXC_NUM_THREAD) && s.spsel;
          n.idx      = 3'h0;
          n.st       = XS_PUSH;
        end else if (exc_return && s.exc_num != EXC_NUM_THREAD) begin
          if (s.exc_num == EXC_NUM_NMI)
            n.nmi_act = 1'b0;
          else if (s.exc_num == EXC_NUM_SVC)
            n.svc_act = 1'b0;
          else if (s.exc_num >= EXC_NUM_IRQ0)
            n.act[ret_irq] = 1'b0;
          n.pop_psp = ret_to_psp;
          n.st      = XS_RETURN;
        end
      end
      XS_PUSH: begin
        n.idx = s.idx + 3'h1;
        if (s.idx == STACK_XPSR_IDX) begin
          if (s.push_psp)
            n.process_stack_ptr = s.frame;
          else
            n.main_stack_ptr = s.frame;
          n.exc_num = s.tgt;
          n.st      = XS_VECTOR;
        end
      end
      XS_VECTOR: n.st = XS_RUN;
      XS_RETURN: begin
        if (take_ok) begin
          // tail-chain: frame already on the stack, skip unstacking
          act_go    = 1'b1;
          n.exc_num = cand_num;
          n.st      = XS_VECTOR;
        end else begin
          n.idx = 3'h0;
          n.st  = XS_POP;
        end
      end
      XS_POP: begin
        n.idx = s.idx + 3'h1;
        if (s.idx == STACK_XPSR_IDX) begin
          n.flags   = stk_rdata[FLAG_MSB:FLAG_LSB];
          n.exc_num = stk_rdata[EXC_NUM_W-1:0];
          if (s.pop_psp)
            n.process_stack_ptr = pop_base + STACK_FRAME_BYTES;
          else
            n.main_stack_ptr = pop_base + STACK_FRAME_BYTES;
          if (ret_to_psp || s.pop_psp)
            n.spsel = s.pop_psp;
          n.st = XS_RUN;
        end
      end
      default: n.st = XS_RUN;
    endcase

    if (act_go) begin
      if (act_num == EXC_NUM_NMI) begin
        n.nmi_act  = 1'b1;
        n.nmi_pend = 1'b0;
      end else if (act_num == EXC_NUM_SVC) begin
        n.svc_act  = 1'b1;
        n.svc_pend = 1'b0;
      end else begin
        n.act[act_irq]     = 1'b1;
        ent_clr[act_irq]   = 1'b1;
      end
    end

    // a line edge or held line re-pends; hardware set beats any clear
    hw_set = (irq_line & ~n.act) | (irq_line & ~s.line_q);
    pset   = (sw_set | hw_set) & IMPL;
    n.pend = (s.pend & ~sw_clr & ~ent_clr) | pset;
    if (nmi_line && !s.nmi_q)
      n.nmi_pend = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s        <= '0;
      s.en     <= RST_IRQ_ENABLE;
      s.pend   <= RST_IRQ_PENDING;
      s.prio   <= {IRQ_MAX{RST_IRQ_PRIORITY}};
      s.st     <= XS_RUN;
    end else begin
      s <= n;
    end
  end

  csic_wait_unit #(.EVENT_WAIT_EN(EVENT_WAIT_EN)) u_wait (
    .clk                  (clk),
    .rst_b                (rst_b),
    .do_sev               (issue && instr.op == OP_SEND_EVENT),
    .do_wfe               (issue && instr.op == OP_WAIT_EVENT),
    .do_wfi               (issue && instr.op == OP_WAIT_IRQ),
    .wake_exc             (take_ok),
    .wake_pend            (|(pset & ~s.pend)),
    .wake_irq             (cand_v && cand_xp < cur_xp),
    .wake_on_pending_flag (wake_on_pending_flag),
    .dbg_req              (dbg_req),
    .dbg_en               (dbg_en),
    .ext_event            (ext_event),
    .stall                (wait_stall),
    .tx_event             (tx_event)
  );

  assign instr_stall  = (s.st != XS_RUN) | wait_stall;
  assign gpr_we       = s.gpr_we;
  assign gpr_wdata    = s.gpr_wdata;
  assign pipe_flush   = s.flush;
  assign app_flags    = s.flags;
  assign exc_num      = s.exc_num;
  assign vec_req      = (s.st == XS_VECTOR);
  assign ppb_rsp      = '{ready: s.rsp_ready, err: s.rsp_err,
                          rdata: s.rsp_rdata};
  assign sel_systimer = ppb_req.sel & tmr_hit;
  assign sel_sysctrl  = ppb_req.sel & scb_hit;
  assign ctx_idx      = s.idx;

  always_comb begin
    stk.we    = (s.st == XS_PUSH);
    stk.re    = (s.st == XS_POP);
    stk.addr  = (stk.we ? s.frame : pop_base) + {27'h0, s.idx, 2'b00};
    stk.wdata = (s.idx == STACK_XPSR_IDX) ? status_word(s.flags, s.exc_num)
                                          : ctx_word;
  end
endmodule

// *** test/csic_top_assertions.sv ***
`timescale 1ns/100ps
module csic_top_assertions
  import csic_pkg::*;
(
  input logic          clk,
  input logic          rst_b,
  input csic_instr_t   instr,
  input logic          instr_stall,
  input logic          gpr_we,
  input logic          pipe_flush,
  input logic [3:0]    app_flags,
  input logic [5:0]    exc_num,
  input logic          vec_req,
  input logic          tx_event,
  input csic_ppb_req_t ppb_req,
  input csic_ppb_rsp_t ppb_rsp,
  input csic_stack_t   stk
);
  logic tk;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // an instruction counts only when the core is not held off
  assign tk = instr.valid && !instr_stall;

  AST_FLUSH:
    assert property (tk && instr.op == OP_SYNC_BARRIER |=> pipe_flush)
    else $error("barrier without flush");
  AST_MOVE_FROM:
    assert property (tk && instr.op == OP_MOVE_FROM |=> gpr_we)
    else $error("move-from without write");
  AST_SEND_EVENT:
    assert property (tk && instr.op == OP_SEND_EVENT |=> tx_event)
    else $error("send-event without pulse");
  AST_FLAGS_KEEP:
    assert property (tk && instr.op inside {OP_SYNC_BARRIER, OP_MOVE_FROM,
      OP_NO_OPERATION, OP_SEND_EVENT, OP_SUPER_CALL, OP_WAIT_EVENT,
      OP_WAIT_IRQ} |=> $stable(app_flags))
    else $error("flags changed");
  AST_FLAGS_LOAD:
    assert property (tk && instr.op == OP_MOVE_TO && instr.spec == SPEC_APP
      |=> app_flags == $past(instr.src[31:28]))
    else $error("flags not loaded");
  AST_BUS_IRQC:
    assert property (ppb_req.sel && ppb_req.addr inside
      {[RGN_IRQC_LO:RGN_IRQC_HI]} |=> ppb_rsp.ready && !ppb_rsp.err)
    else $error("controller access unanswered");
  AST_BUS_UNMAPPED:
    assert property (ppb_req.sel && ppb_req.addr < RGN_SCB1_LO
      |=> ppb_rsp.ready && ppb_rsp.err)
    else $error("unmapped access not refused");
  AST_PUSH_VEC:
    assert property ($rose(stk.we) |-> stk.we [*8] ##1 (vec_req && !stk.we))
    else $error("bad stacking frame");

  cover property (vec_req && exc_num == EXC_NUM_SVC);
  cover property (ppb_rsp.ready && ppb_rsp.err);
  cover property (tx_event);
endmodule

// *** test/csic_irq_src.sv ***
`timescale 1ns/100ps
module csic_irq_src (
  input  logic        clk,
  input  logic        rst_b,
  input  logic        fire,
  input  logic        hold,
  input  logic [4:0]  num,
  output logic [31:0] irq_line
);
  // level sources keep the line up, pulse sources drop it a cycle later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) irq_line <= 32'h0;
    else if (fire) irq_line[num] <= 1'b1;
    else if (!hold) irq_line <= 32'h0;
  end
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import csic_pkg::*;
  logic          clk, rst_b, exc_return, ext_event, fire, hold, nmi;
  logic          instr_stall, gpr_we, pipe_flush, vec_req, tx_event;
  logic          sel_systimer, sel_sysctrl;
  logic [2:0]    ctx_idx;
  logic [3:0]    app_flags;
  logic [4:0]    num;
  logic [5:0]    exc_num;
  logic [31:0]   irq_line, gpr_wdata, ctx_word, stk_rdata, rd, a;
  logic [33:0]   e, expq[$];
  csic_instr_t   instr;
  csic_ppb_req_t ppb_req;
  csic_ppb_rsp_t ppb_rsp;
  csic_stack_t   stk;
  int            mismatches, compares, seed, n;

  csic_top u_dut (.*, .nmi_line(nmi), .wake_on_pending_flag(1'b0),
    .dbg_req(1'b0), .dbg_en(1'b0), .ret_to_psp(1'b0));
  csic_irq_src u_src (.*);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [32:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // x: {rdata checked, err, rdata}
  task automatic bus(input logic w, input logic [31:0] ad, d,
                     input logic [33:0] x);
    @(negedge clk);
    ppb_req = '{1'b1, w, ad, d};
    expq.push_back(x);
    @(negedge clk);
    ppb_req.sel = 1'b0;
  endtask

  task automatic op(input csic_op_t o, input logic [31:0] v,
                    input csic_spec_t s = SPEC_APP);
    @(negedge clk);
    instr = '{1'b1, o, s, v};
    @(negedge clk);
    instr.valid = 1'b0;
  endtask

  task automatic vec(input logic r, input logic [5:0] x);
    int k;
    expq.push_back(34'(x));
    @(negedge clk);
    exc_return = r;
    @(negedge clk);
    exc_return = 1'b0;
    for (k = 0; k < 40 && vec_req !== 1'b1; k++) @(negedge clk);
    if (k == 40) begin
      mismatches++;
      print_verdict();
    end
    @(negedge clk);
  endtask

  always @(negedge clk) begin
    {ctx_word, stk_rdata} = {$random(seed), $random(seed)};
    if (rst_b && (ppb_rsp.ready | gpr_we | vec_req) === 1'b1) begin
      e = expq.size() ? expq.pop_front() : '1;
      if (vec_req === 1'b1) check({27'h0, exc_num}, e[32:0]);
      else if (gpr_we === 1'b1) check({1'h0, gpr_wdata}, e[32:0]);
      else check({ppb_rsp.err, e[33] ? ppb_rsp.rdata : e[31:0]},
                 e[32:0]);
    end
  end

  initial begin
    seed = 67293;
    rst_b = 1'b0;
    {instr, ppb_req, exc_return, ext_event, fire, hold, num, nmi} = '0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    for (n = 0; n < 4; n++)
      bus(0, ADDR_IRQ_ENABLE_SET + 32'(n * 128), 0, {2'h2, 32'h0});
    for (n = 0; n < 8; n++) begin
      rd = $random(seed);
      a = ADDR_IRQ_PRIORITY_BASE + 32'(n * 4);
      bus(0, a, 0, {2'h2, 32'h0});
      bus(1, a, rd, 34'h0);
      bus(0, a, 0, {2'h2, rd & 32'hC0C0_C0C0});
    end
    bus(0, 32'hE000_0000, 0, 34'h1_0000_0000);
    @(negedge clk);
    ppb_req = '{1'b1, 1'b0, RGN_TMR_LO, 32'h0};
    #1 check({32'h0, sel_systimer}, 33'h1);
    ppb_req.addr = RGN_SCB2_LO;
    #1 check({32'h0, sel_sysctrl}, 33'h1);
    @(negedge clk);
    ppb_req.sel = 1'b0;
    bus(1, ADDR_IRQ_PENDING_SET, 32'h80, 34'h0);
    bus(1, ADDR_IRQ_PENDING_SET, 32'h0, 34'h0);
    bus(0, ADDR_IRQ_PENDING_SET, 0, {2'h2, 32'h80});
    bus(1, ADDR_IRQ_PENDING_CLEAR, 32'h80, 34'h0);
    bus(0, ADDR_IRQ_PENDING_CLEAR, 0, {2'h2, 32'h0});
    rd = $random(seed);
    op(OP_MOVE_TO, rd);
    expq.push_back({2'h2, rd[31:28], 28'h0});
    op(OP_MOVE_FROM, 0);
    op(OP_MOVE_TO, 1, SPEC_IRQ_MASK);
    expq.push_back({2'h2, 32'h1});
    op(OP_MOVE_FROM, 0, SPEC_IRQ_MASK);
    op(OP_MOVE_TO, 0, SPEC_IRQ_MASK);
    op(OP_SYNC_BARRIER, 0);
    op(OP_NO_OPERATION, 0);
    op(OP_SEND_EVENT, 0);
    op(OP_WAIT_EVENT, 0);
    check({32'h0, instr_stall}, 33'h0);
    op(OP_WAIT_EVENT, 0);
    check({32'h0, instr_stall}, 33'h1);
    ext_event = 1'b1;
    @(negedge clk);
    ext_event = 1'b0;
    for (n = 0; n < 8 && instr_stall !== 1'b0; n++) @(negedge clk);
    check({32'h0, instr_stall}, 33'h0);
    bus(1, ADDR_IRQ_PRIORITY_BASE, 32'h0040_0000, 34'h0);
    bus(1, ADDR_IRQ_PRIORITY_BASE + 32'h4, 0, 34'h0);
    bus(1, ADDR_IRQ_PRIORITY_BASE + 32'h8, 0, 34'h0);
    {fire, num, hold} = {1'b1, 5'h2, 1'b0};
    @(negedge clk);
    {fire, num, hold} = {1'b1, 5'h9, 1'b1};
    @(negedge clk);
    fire = 1'b0;
    bus(1, ADDR_IRQ_PENDING_SET, 32'h10, 34'h0);
    bus(0, ADDR_IRQ_PENDING_SET, 0, {2'h2, 32'h214});
    hold = 1'b0;
    op(OP_SUPER_CALL, rd);
    vec(1'b0, EXC_NUM_SVC);
    bus(1, ADDR_IRQ_ENABLE_SET, 32'h214, 34'h0);
    vec(1'b1, EXC_NUM_IRQ0 + 6'h4);
    vec(1'b1, EXC_NUM_IRQ0 + 6'h9);
    vec(1'b1, EXC_NUM_IRQ0 + 6'h2);
    op(OP_WAIT_IRQ, 0);
    check({32'h0, instr_stall}, 33'h1);
    bus(1, ADDR_IRQ_PENDING_SET, 32'h10, 34'h0);
    vec(1'b0, EXC_NUM_IRQ0 + 6'h4);
    check({32'h0, instr_stall}, 33'h0);
    nmi = 1'b1;
    vec(1'b0, EXC_NUM_NMI);
    print_verdict();
  end
endmodule

bind csic_top csic_top_assertions u_chk (.*);
